// ==== drq_host_model.sv ====
// host model: reads the received digit on the fall of the valid strobe
// assumes strobe and digit come from the qualifier on clk_sys_in
`timescale 1ns/1ps

module drq_host_model
(
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  // qualifier outputs, only ever read
  input  wire logic       digit_valid_strobe_n_in,
  input  wire logic [3:0] received_digit_in,
  // captured value
  output logic [3:0]      host_digit_out,
  output logic [7:0]      host_reads_out
);
  logic strobe_n_q;

  // capture on the falling strobe only, the code may still settle before it
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      strobe_n_q     <= 1'b1;
      host_digit_out <= 4'h0;
      host_reads_out <= 8'h00;
    end
    else
    begin
      strobe_n_q <= digit_valid_strobe_n_in;
      if (strobe_n_q && !digit_valid_strobe_n_in)
      begin
        host_digit_out <= received_digit_in;
        host_reads_out <= host_reads_out + 8'h01;
      end
    end
  end
endmodule : drq_host_model

// ==== drq_pkg.sv ====
// constants, state encoding and timing counts of the receive qualifier
// assumes a 40 MHz system clock and a 0.1 ms qualification tick
//
// Operation
// - a tone pair that lasts 35 ms (high speed) or 49 ms (normal) is taken as a valid digit.
// - a tone of at most 10 ms (high speed) or 24 ms (normal) is ignored with no strobe or digit.
// - a silence of at least 21 ms or 30 ms clears the digit output and releases the strobe.
// - a tone change with no long gap keeps the strobe low and the first digit in place.
// - before the strobe falls, drop-outs of up to 0.4 ms do not abort acceptance.
// - while the strobe is low, drop-outs of up to 3 ms or 10 ms do not reset the outputs.
// - the digit code appears 12 to 37 ms (high speed) or 24 to 49 ms (normal) after the tone.
// - strobe and digit stop 15 to 27 ms or 24 to 35 ms after the tone disappears.
// - the strobe falls 0.2 to 1.0 ms after the digit code becomes valid.
// - digit and status are read-only outputs, the control register is write-only.
// - a high power-down pin resets the control register with its speed-select bit.

package drq_pkg;

  // ----------------------------------------------------------------
  // clock and tick
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_NS       = 100000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_UNIT_US  = TICK_NS / 1000;
  localparam int TICK_W        = 12;
  localparam int CNT_W         = 10;

  // ----------------------------------------------------------------
  // qualification times in microseconds
  // ----------------------------------------------------------------
  localparam int ACCEPT_HS_US = 20000;   // between 10 and 35 ms
  localparam int ACCEPT_NM_US = 36000;   // between 24 and 49 ms
  localparam int BRK1_US      = 400;
  localparam int SP_DELAY_US  = 500;     // inside 0.2 .. 1.0 ms
  localparam int HOLD_HS_US   = 18000;   // above 3 ms drop-out, below 21 ms pause
  localparam int HOLD_NM_US   = 27000;   // above 10 ms drop-out, below 30 ms pause

  localparam logic [CNT_W-1:0] ACCEPT_HS_TICKS = CNT_W'(ACCEPT_HS_US / TICK_UNIT_US);
  localparam logic [CNT_W-1:0] ACCEPT_NM_TICKS = CNT_W'(ACCEPT_NM_US / TICK_UNIT_US);
  localparam logic [CNT_W-1:0] BRK1_TICKS      = CNT_W'(BRK1_US / TICK_UNIT_US);
  localparam logic [CNT_W-1:0] SP_TICKS        = CNT_W'(SP_DELAY_US / TICK_UNIT_US);
  localparam logic [CNT_W-1:0] HOLD_HS_TICKS   = CNT_W'(HOLD_HS_US / TICK_UNIT_US);
  localparam logic [CNT_W-1:0] HOLD_NM_TICKS   = CNT_W'(HOLD_NM_US / TICK_UNIT_US);

  // ----------------------------------------------------------------
  // control word layout and reset values
  // ----------------------------------------------------------------
  localparam int         CTRL_SPEED_BIT = 2;
  localparam logic       CTRL_SPEED_RST = 1'b0;
  localparam int         STAT_STROBE_BIT = 3;
  localparam logic [3:0] DIGIT_RST      = 4'h0;

  typedef enum logic [1:0] {
    DRQ_IDLE   = 2'b00,
    DRQ_QUAL   = 2'b01,
    DRQ_DELAY  = 2'b10,
    DRQ_ACTIVE = 2'b11
  } drq_state_t;

endpackage : drq_pkg

// ==== drq_qualifier.sv ====
// dtmf receive qualifier: acceptance, drop-out bridging, pause detect, strobe
// assumes tone indication and code come from detector logic on clk_sys_in;
// the power-down pin is asynchronous and is synchronised here
`timescale 1ns/1ps

module drq_qualifier
  import drq_pkg::*;
#(
  // cycles per 0.1 ms tick; a bench may shorten it, all intervals are counted in ticks
  parameter int TICK_LEN = TICK_CYCLES
)
(
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  // power-down pin
  input  wire logic       power_down_pin_in,
  // frequency detector
  input  wire logic       tone_present_in,
  input  wire logic [3:0] tone_digit_in,
  // control word write port
  input  wire logic       control_reg_wr_in,
  input  wire logic [3:0] control_reg_data_in,
  // host side
  output logic [3:0]      received_digit_reg_out,
  output logic [3:0]      status_reg_out,
  output logic            digit_valid_strobe_n_out,
  output logic            detect_speed_select_out
);

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic [CNT_W-1:0] pick(input logic hs,
                                            input logic [CNT_W-1:0] a,
                                            input logic [CNT_W-1:0] b);
    pick = hs ? a : b;
  endfunction : pick

  drq_tick_if tk ();

  drq_tick_gen #(
    .TICK_LEN   (TICK_LEN)
  ) u_tick (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .tk         (tk)
  );

  // --------------------------------------------------------------
  // power-down synchroniser and control word
  // --------------------------------------------------------------
  logic pd_meta_q;
  logic pd_sync_q;
  logic speed_q;
  logic speed_d;

  // power-down only matters once it is clean in this domain
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pd_meta_q <= 1'b0;
      pd_sync_q <= 1'b0;
    end
    else
    begin
      pd_meta_q <= power_down_pin_in;
      pd_sync_q <= pd_meta_q;
    end
  end

  // write-only control word, only the speed bit has a user here
  always_comb
  begin
    speed_d = speed_q;
    if (pd_sync_q)
      speed_d = CTRL_SPEED_RST;
    else if (control_reg_wr_in)
      speed_d = control_reg_data_in[CTRL_SPEED_BIT];
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      speed_q <= CTRL_SPEED_RST;
    else
      speed_q <= speed_d;
  end

  // --------------------------------------------------------------
  // qualification state
  // --------------------------------------------------------------
  drq_state_t       state_q;
  drq_state_t       state_d;
  logic [CNT_W-1:0] run_q;
  logic [CNT_W-1:0] run_d;
  logic [CNT_W-1:0] gap_q;
  logic [CNT_W-1:0] gap_d;
  logic [3:0]       digit_q;
  logic [3:0]       digit_d;
  logic             strobe_n_q;
  logic             strobe_n_d;
  logic [CNT_W-1:0] accept_ticks;
  logic [CNT_W-1:0] hold_ticks;

  assign accept_ticks = pick(speed_q, ACCEPT_HS_TICKS, ACCEPT_NM_TICKS);
  assign hold_ticks   = pick(speed_q, HOLD_HS_TICKS, HOLD_NM_TICKS);
  assign tk.clear     = (state_q == DRQ_IDLE) && tone_present_in;

  // next state; counters only move on the 0.1 ms tick
  always_comb
  begin
    state_d    = state_q;
    run_d      = run_q;
    gap_d      = gap_q;
    digit_d    = digit_q;
    strobe_n_d = strobe_n_q;
    case (state_q)
      DRQ_IDLE:
      begin
        run_d = '0;
        gap_d = '0;
        if (tone_present_in)
          state_d = DRQ_QUAL;
      end
      DRQ_QUAL, DRQ_DELAY:
      begin
        if (tk.tick)
        begin
          run_d = run_q + CNT_W'(1);
          gap_d = tone_present_in ? '0 : gap_q + CNT_W'(1);
          // a gap past 0.4 ms means the tone was short: drop it
          if (!tone_present_in && gap_q == BRK1_TICKS)
          begin
            state_d = DRQ_IDLE;
            digit_d = DIGIT_RST;
          end
          else if (state_q == DRQ_QUAL && run_d >= accept_ticks)
          begin
            state_d = DRQ_DELAY;
            run_d   = '0;
            digit_d = tone_digit_in;
          end
          else if (state_q == DRQ_DELAY && run_q == SP_TICKS - CNT_W'(1))
          begin
            state_d    = DRQ_ACTIVE;
            strobe_n_d = 1'b0;
          end
        end
      end
      DRQ_ACTIVE:
      begin
        // code changes are ignored: the first digit stays up
        if (tk.tick)
        begin
          gap_d = tone_present_in ? '0 : gap_q + CNT_W'(1);
          // at or past the limit: a speed switch mid-digit must not let the gap run past it
          if (!tone_present_in && gap_q >= hold_ticks - CNT_W'(1))
          begin
            state_d    = DRQ_IDLE;
            digit_d    = DIGIT_RST;
            strobe_n_d = 1'b1;
          end
        end
      end
      default:
      begin
        state_d    = DRQ_IDLE;
        digit_d    = DIGIT_RST;
        strobe_n_d = 1'b1;
      end
    endcase
    // power-down behaves as a reset of the whole receiver
    if (pd_sync_q)
    begin
      state_d    = DRQ_IDLE;
      run_d      = '0;
      gap_d      = '0;
      digit_d    = DIGIT_RST;
      strobe_n_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_q    <= DRQ_IDLE;
      run_q      <= '0;
      gap_q      <= '0;
      digit_q    <= DIGIT_RST;
      strobe_n_q <= 1'b1;
    end
    else
    begin
      state_q    <= state_d;
      run_q      <= run_d;
      gap_q      <= gap_d;
      digit_q    <= digit_d;
      strobe_n_q <= strobe_n_d;
    end
  end

  // read-only views for the host; the digit is latched on acceptance, 0.5 ms before the strobe falls
  assign received_digit_reg_out   = digit_q;
  assign status_reg_out           = {strobe_n_q, 3'b000};
  assign digit_valid_strobe_n_out = strobe_n_q;
  assign detect_speed_select_out  = speed_q;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  a_accept_entry: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (state_q == DRQ_QUAL && tk.tick && !pd_sync_q && run_q + CNT_W'(1) >= accept_ticks
     && !(!tone_present_in && gap_q == BRK1_TICKS)) |=> state_q == DRQ_DELAY)
    else $error("accept time reached but digit not taken");

  a_short_reject: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (state_q == DRQ_QUAL && tk.tick && !tone_present_in && gap_q == BRK1_TICKS)
    |=> state_q == DRQ_IDLE && strobe_n_q && digit_q == DIGIT_RST)
    else $error("short tone not rejected");

  a_pause_clear: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (state_q == DRQ_ACTIVE && tk.tick && !tone_present_in
     && gap_q >= hold_ticks - CNT_W'(1)) |=> strobe_n_q && digit_q == DIGIT_RST)
    else $error("pause did not clear outputs");

  a_digit_steady: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (state_q == DRQ_ACTIVE && $past(state_q) == DRQ_ACTIVE) |-> $stable(digit_q))
    else $error("digit changed while strobe low");

  a_dropout_bridge: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (state_q == DRQ_ACTIVE && !pd_sync_q && gap_q < hold_ticks - CNT_W'(1))
    |=> !strobe_n_q)
    else $error("strobe released inside drop-out window");

  a_strobe_delay: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $fell(strobe_n_q) |-> $past(state_q) == DRQ_DELAY && $past(run_q) == SP_TICKS - CNT_W'(1))
    else $error("strobe fell without the set delay");

  a_strobe_digit: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !strobe_n_q |-> state_q == DRQ_ACTIVE && $stable(digit_q) || $fell(strobe_n_q))
    else $error("strobe low without settled digit");

  a_pd_reset: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    pd_sync_q |=> !speed_q && strobe_n_q && state_q == DRQ_IDLE)
    else $error("power-down did not reset control");

endmodule : drq_qualifier

// ==== drq_qualifier_tb.sv ====
// testbench of the dtmf receive qualifier with a host model
// assumes drq_pkg, the tick carrier, the design and the host model are compiled first
`timescale 1ns/1ps

module drq_qualifier_tb
  import drq_pkg::*;
  ();
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int TB_TICK = 20;           // shortened tick keeps the run small
  localparam int MS = 10 * TB_TICK;      // clock cycles per ms of tone time
  logic       clk_sys_in, rst_in, power_down_pin_in, tone_present_in, control_reg_wr_in;
  logic [3:0] tone_digit_in, control_reg_data_in, received_digit_reg_out, status_reg_out;
  logic       digit_valid_strobe_n_out, detect_speed_select_out;
  logic [3:0] host_digit;
  logic [7:0] host_reads;
  int         error_cnt, samples_checked;

  drq_qualifier #(.TICK_LEN(TB_TICK)) dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .power_down_pin_in(power_down_pin_in), .tone_present_in(tone_present_in),
    .tone_digit_in(tone_digit_in), .control_reg_wr_in(control_reg_wr_in),
    .control_reg_data_in(control_reg_data_in), .received_digit_reg_out(received_digit_reg_out),
    .status_reg_out(status_reg_out), .digit_valid_strobe_n_out(digit_valid_strobe_n_out),
    .detect_speed_select_out(detect_speed_select_out));
  drq_host_model host (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .digit_valid_strobe_n_in(digit_valid_strobe_n_out), .received_digit_in(received_digit_reg_out),
    .host_digit_out(host_digit), .host_reads_out(host_reads));

  // ----------------------------------------------------------------
  // helpers; the timed ones are entered and left at a rising edge, chk and chk_rng take no time
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_rng(input int n, input int lo, input int hi);
    samples_checked++;
    if (n < lo || n > hi)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h to %h", $time, n, lo, hi);
    end
  endtask : chk_rng

  // holds the tone input for cyc cycles, counting cycles with strobe low
  task automatic drive(input logic on, input logic [3:0] code, input int cyc, output int lows);
    lows = 0;
    tone_present_in <= on;
    tone_digit_in   <= code;
    repeat (cyc)
    begin
      @(negedge clk_sys_in);
      if (digit_valid_strobe_n_out === 1'b0) lows++;
      @(posedge clk_sys_in);
    end
  endtask : drive

  // kind 0: digit shown, 1: strobe low, 2: strobe high; bounded wait
  task automatic wait_ev(input int kind, input int lim, output int n);
    n = 0;
    @(negedge clk_sys_in);
    while (n < lim && !((kind == 0 && received_digit_reg_out !== 4'h0) ||
           (kind == 1 && digit_valid_strobe_n_out === 1'b0) ||
           (kind == 2 && digit_valid_strobe_n_out === 1'b1)))
    begin
      @(negedge clk_sys_in);
      n++;
    end
    @(posedge clk_sys_in);
  endtask : wait_ev

  task automatic wr_speed(input logic hs, input logic exp);
    control_reg_wr_in   <= 1'b1;
    control_reg_data_in <= hs ? 4'h4 : 4'h0;
    @(posedge clk_sys_in);
    control_reg_wr_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    chk(detect_speed_select_out, exp);
    @(posedge clk_sys_in);
  endtask : wr_speed

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // speed bit set, then power-down clears it and refuses a write
  task automatic t_power_down();
    wr_speed(1'b1, 1'b1);
    power_down_pin_in <= 1'b1;
    repeat (5) @(posedge clk_sys_in);
    wr_speed(1'b1, 1'b0);
    power_down_pin_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
  endtask : t_power_down

  // longest tone that must be ignored, in both speeds
  task automatic t_reject();
    int lows;
    for (int m = 1; m >= 0; m--)
    begin
      wr_speed(m[0], m[0]);
      drive(1'b1, 4'h3, m ? 10 * MS : 24 * MS, lows);
      chk(lows, 0);
      drive(1'b0, 4'h0, 40 * MS, lows); // spacing kept by the source
      chk(lows, 0);
      chk(received_digit_reg_out, 4'h0);
    end
  endtask : t_reject

  // one digit with drop-outs before and after the strobe and a code change
  task automatic run_digit(input logic hs, input logic [3:0] code, input int drop2);
    int lows, n, t;
    wr_speed(hs, hs);
    drive(1'b1, code, 5 * MS, lows);
    drive(1'b0, code, 35 * MS / 100, lows); // 0.35 ms drop-out must be bridged
    tone_present_in <= 1'b1;
    wait_ev(0, 60 * MS, n);
    t = 5 * MS + 35 * MS / 100 + n;
    chk_rng(t, hs ? 12 * MS : 24 * MS, hs ? 37 * MS : 49 * MS);
    chk(received_digit_reg_out, code);
    wait_ev(1, 2 * MS, n);
    chk_rng(n, MS / 5, MS);
    @(negedge clk_sys_in);
    chk(host_digit, code);
    chk(status_reg_out, 4'h0);
    @(posedge clk_sys_in);
    drive(1'b0, code, drop2, lows);
    chk(lows, drop2);
    drive(1'b1, code ^ 4'hf, 2 * MS, lows);
    chk(lows, 2 * MS);
    chk(received_digit_reg_out, code);
    tone_present_in <= 1'b0;
    wait_ev(2, 40 * MS, n);
    chk_rng(n, hs ? 15 * MS : 24 * MS, hs ? 27 * MS : 35 * MS);
    @(negedge clk_sys_in);
    chk(received_digit_reg_out, 4'h0);
    chk(status_reg_out, 4'h8);
    @(posedge clk_sys_in);
    drive(1'b0, 4'h0, 40 * MS, lows); // pause before the next digit
  endtask : run_digit

  // ----------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end

  // whole run is about 320 ms of tone time, 450 ms is the limit
  initial
  begin
    repeat (450 * MS) @(posedge clk_sys_in);
    error_cnt++;
    finish_test();
  end

  initial
  begin
    rst_in = 1'b1;
    power_down_pin_in = 1'b0;
    tone_present_in = 1'b0;
    tone_digit_in = 4'h0;
    control_reg_wr_in = 1'b0;
    control_reg_data_in = 4'h0;
    error_cnt = 0;
    samples_checked = 0;
    repeat (5) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(negedge clk_sys_in);
    chk({received_digit_reg_out, status_reg_out}, 8'h08);
    chk({digit_valid_strobe_n_out, detect_speed_select_out}, 2'b10);
    @(posedge clk_sys_in);
    t_power_down();
    t_reject();
    run_digit(1'b1, 4'h5, 3 * MS);
    run_digit(1'b0, 4'hc, 10 * MS);
    chk(host_reads, 8'h02);
    finish_test();
  end
endmodule : drq_qualifier_tb

// ==== drq_tick_gen.sv ====
// prescaler making the 0.1 ms qualification tick
// assumes clk_sys_in at 40 MHz and rst_in asynchronous active high
`timescale 1ns/1ps

module drq_tick_gen
  import drq_pkg::*;
#(
  // cycles per qualification tick
  parameter int TICK_LEN = TICK_CYCLES
)
(
  // clock and reset
  input  wire logic clk_sys_in,
  input  wire logic rst_in,
  // tick carrier
  drq_tick_if.gen   tk
);

  logic [TICK_W-1:0] cnt_q;
  logic [TICK_W-1:0] cnt_d;
  logic              tick_q;
  logic              tick_d;

  // --------------------------------------------------------------
  // next count
  // --------------------------------------------------------------
  always_comb
  begin
    tick_d = 1'b0;
    cnt_d  = cnt_q + TICK_W'(1);
    if (tk.clear)
    begin
      cnt_d = '0;
    end
    else if (cnt_q == TICK_W'(TICK_LEN - 1))
    begin
      cnt_d  = '0;
      tick_d = 1'b1;
    end
  end

  // registers
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tk.tick = tick_q;

endmodule : drq_tick_gen

// ==== drq_tick_if.sv ====
// tick carrier between the prescaler and the qualifier
// assumes both ends run on the same system clock
`timescale 1ns/1ps

interface drq_tick_if;
  logic tick;   // one-cycle pulse every 0.1 ms
  logic clear;  // restarts the prescaler phase

  modport gen (output tick, input clear);
  modport use_tick (input tick, output clear);
endinterface : drq_tick_if
